/* File: design/bidir_mailbox_fifo.sv */
// Top of the bidirectional two-queue buffer with one mailbox per direction
//
// Summary of operation
// - Two 512x36 queues, left-to-right and right-to-left
// - One 36-bit mailbox per direction bypasses queues
// - Each mailbox flag marks unread new mail
// - Transfers happen on qualified rising port-clock edges
// - Port clocks handled independently, any phase relation
// - Input-ready, almost-full synced to writing port
// - Output-ready, almost-empty synced to reading port
// - Offsets programmed only through the left port
// - Left almost-empty low when reverse count <= offset
// - Right almost-empty low when forward count <= offset
// - Left almost-full low when forward free <= offset
// - Right almost-full low when reverse free <= offset
// - 36-bit two-way data bus per port
// - Input-ready low when full, rises third edge
// - Output-ready low when empty, rises third edge
// - Mail write lowers flag; opposite mail read raises
`timescale 1ns/1ps
`default_nettype none
module bidir_mailbox_fifo
	import mailbox_fifo_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              left_port_clock_i,
	input  wire logic              left_select_n_i,
	input  wire logic              left_port_enable_i,
	input  wire logic              left_write_i,
	input  wire logic              left_mail_select_i,
	input  wire logic              left_program_i,
	input  wire logic [DATA_W-1:0] left_data_bus_i,
	output logic      [DATA_W-1:0] left_data_bus_o,
	output logic                   left_data_bus_oe_o,
	output logic                   left_input_ready_o,
	output logic                   left_output_ready_o,
	output logic                   left_almost_full_n_o,
	output logic                   left_almost_empty_n_o,
	input  wire logic              right_port_clock_i,
	input  wire logic              right_select_n_i,
	input  wire logic              right_port_enable_i,
	input  wire logic              right_write_i,
	input  wire logic              right_mail_select_i,
	input  wire logic [DATA_W-1:0] right_data_bus_i,
	output logic      [DATA_W-1:0] right_data_bus_o,
	output logic                   right_data_bus_oe_o,
	output logic                   right_input_ready_o,
	output logic                   right_output_ready_o,
	output logic                   right_almost_full_n_o,
	output logic                   right_almost_empty_n_o,
	output logic                   forward_mail_flag_n_o,
	output logic                   reverse_mail_flag_n_o
);
	logic              lclk_reg, rclk_reg, left_tick, right_tick;
	logic              left_access, right_access, left_wr, left_rd, right_wr, right_rd;
	logic              fwd_push, rev_push, fwd_take, rev_take;
	logic              fwd_mail_wr, rev_mail_wr, fwd_mail_rd, rev_mail_rd, prog_wr;
	logic [DATA_W-1:0] forward_mailbox_reg, forward_mailbox_next;
	logic [DATA_W-1:0] reverse_mailbox_reg, reverse_mailbox_next;
	logic              fwd_flag_reg, fwd_flag_next, rev_flag_reg, rev_flag_next;
	logic [DATA_W-1:0] ldata_reg, ldata_next, rdata_reg, rdata_next;
	logic [THR_W-1:0]  forward_full_threshold_reg, forward_full_threshold_next;
	logic [THR_W-1:0]  forward_empty_threshold_reg, forward_empty_threshold_next;
	logic [THR_W-1:0]  reverse_full_threshold_reg, reverse_full_threshold_next;
	logic [THR_W-1:0]  reverse_empty_threshold_reg, reverse_empty_threshold_next;
	logic [1:0]        prog_idx_reg, prog_idx_next;
	prog_state_t       prog_state_reg, prog_state_next;
	logic              fwd_ir, rev_ir, fwd_valid, rev_valid, fbuf_ready, rbuf_ready;
	logic              fbuf_valid, rbuf_valid;
	logic [DATA_W-1:0] fwd_word, rev_word, fbuf_data, rbuf_data;
	logic [HELD_W-1:0] fbuf_count, rbuf_count;

	// Port clocks are sampled inputs; their rising edges become ticks
	assign left_tick    = left_port_clock_i & ~lclk_reg;
	assign right_tick   = right_port_clock_i & ~rclk_reg;
	assign left_access  = left_tick & ~left_select_n_i & left_port_enable_i;
	assign right_access = right_tick & ~right_select_n_i & right_port_enable_i;
	assign left_wr      = left_access & left_write_i;
	assign left_rd      = left_access & ~left_write_i;
	assign right_wr     = right_access & right_write_i;
	assign right_rd     = right_access & ~right_write_i;

	assign prog_wr     = left_wr & left_program_i & (prog_state_reg == PROG_ACTIVE);
	assign fwd_push    = left_wr & ~left_mail_select_i & ~left_program_i;
	assign rev_push    = right_wr & ~right_mail_select_i;
	assign fwd_mail_wr = left_wr & left_mail_select_i & ~left_program_i & fwd_flag_reg;
	assign rev_mail_wr = right_wr & right_mail_select_i & rev_flag_reg;
	assign fwd_mail_rd = right_rd & right_mail_select_i;
	assign rev_mail_rd = left_rd & left_mail_select_i;
	assign fwd_take    = right_rd & ~right_mail_select_i & fbuf_valid;
	assign rev_take    = left_rd & ~left_mail_select_i & rbuf_valid;

	// Mailbox state; a write in the same cycle as a far-side read wins
	always_comb
	begin
		forward_mailbox_next = forward_mailbox_reg;
		reverse_mailbox_next = reverse_mailbox_reg;
		fwd_flag_next        = fwd_flag_reg;
		rev_flag_next        = rev_flag_reg;
		if (fwd_mail_rd)
			fwd_flag_next = 1'b1;
		if (fwd_mail_wr)
		begin
			forward_mailbox_next = left_data_bus_i;
			fwd_flag_next        = 1'b0;
		end
		if (rev_mail_rd)
			rev_flag_next = 1'b1;
		if (rev_mail_wr)
		begin
			reverse_mailbox_next = right_data_bus_i;
			rev_flag_next        = 1'b0;
		end
	end

	// Output data is re-registered each cycle so the bus comes from flops
	always_comb
	begin
		ldata_next = left_mail_select_i ? reverse_mailbox_reg : rbuf_data;
		rdata_next = right_mail_select_i ? forward_mailbox_reg : fbuf_data;
	end

	// Four offset words in a fixed order; later program writes are ignored
	always_comb
	begin
		forward_full_threshold_next  = forward_full_threshold_reg;
		forward_empty_threshold_next = forward_empty_threshold_reg;
		reverse_full_threshold_next  = reverse_full_threshold_reg;
		reverse_empty_threshold_next = reverse_empty_threshold_reg;
		prog_idx_next                = prog_idx_reg;
		prog_state_next              = prog_state_reg;
		case (prog_state_reg)
			PROG_ACTIVE:
			begin
				if (prog_wr)
				begin
					case (prog_idx_reg)
						PROG_FWD_FULL:  forward_full_threshold_next  = left_data_bus_i[THR_W-1:0];
						PROG_FWD_EMPTY: forward_empty_threshold_next = left_data_bus_i[THR_W-1:0];
						PROG_REV_FULL:  reverse_full_threshold_next  = left_data_bus_i[THR_W-1:0];
						default:        reverse_empty_threshold_next = left_data_bus_i[THR_W-1:0];
					endcase
					prog_idx_next = prog_idx_reg + PROG_STEP;
					if (prog_idx_reg == PROG_REV_EMPTY)
						prog_state_next = PROG_DONE;
				end
			end
			PROG_DONE: prog_state_next = PROG_DONE;
			default:   prog_state_next = PROG_ACTIVE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			// Track the pins in reset so release shows no false edge
			lclk_reg                    <= left_port_clock_i;
			rclk_reg                    <= right_port_clock_i;
			forward_mailbox_reg         <= DATA_ZERO;
			reverse_mailbox_reg         <= DATA_ZERO;
			fwd_flag_reg                <= 1'b1;
			rev_flag_reg                <= 1'b1;
			ldata_reg                   <= DATA_ZERO;
			rdata_reg                   <= DATA_ZERO;
			forward_full_threshold_reg  <= THR_RESET;
			forward_empty_threshold_reg <= THR_RESET;
			reverse_full_threshold_reg  <= THR_RESET;
			reverse_empty_threshold_reg <= THR_RESET;
			prog_idx_reg                <= PROG_FWD_FULL;
			prog_state_reg              <= PROG_ACTIVE;
		end
		else
		begin
			lclk_reg                    <= left_port_clock_i;
			rclk_reg                    <= right_port_clock_i;
			forward_mailbox_reg         <= forward_mailbox_next;
			reverse_mailbox_reg         <= reverse_mailbox_next;
			fwd_flag_reg                <= fwd_flag_next;
			rev_flag_reg                <= rev_flag_next;
			ldata_reg                   <= ldata_next;
			rdata_reg                   <= rdata_next;
			forward_full_threshold_reg  <= forward_full_threshold_next;
			forward_empty_threshold_reg <= forward_empty_threshold_next;
			reverse_full_threshold_reg  <= reverse_full_threshold_next;
			reverse_empty_threshold_reg <= reverse_empty_threshold_next;
			prog_idx_reg                <= prog_idx_next;
			prog_state_reg              <= prog_state_next;
		end
	end

	queue_core forward_queue (
		.clock_i          (clock_i),
		.rst_n_i          (rst_n_i),
		.wr_tick_i        (left_tick),
		.push_i           (fwd_push),
		.wdata_i          (left_data_bus_i),
		.full_thr_i       (forward_full_threshold_reg),
		.input_ready_o    (fwd_ir),
		.almost_full_n_o  (left_almost_full_n_o),
		.rd_tick_i        (right_tick),
		.pop_i            (fbuf_ready),
		.held_i           (fbuf_count),
		.empty_thr_i      (forward_empty_threshold_reg),
		.pop_valid_o      (fwd_valid),
		.rdata_o          (fwd_word),
		.almost_empty_n_o (right_almost_empty_n_o)
	);

	queue_core reverse_queue (
		.clock_i          (clock_i),
		.rst_n_i          (rst_n_i),
		.wr_tick_i        (right_tick),
		.push_i           (rev_push),
		.wdata_i          (right_data_bus_i),
		.full_thr_i       (reverse_full_threshold_reg),
		.input_ready_o    (rev_ir),
		.almost_full_n_o  (right_almost_full_n_o),
		.rd_tick_i        (left_tick),
		.pop_i            (rbuf_ready),
		.held_i           (rbuf_count),
		.empty_thr_i      (reverse_empty_threshold_reg),
		.pop_valid_o      (rev_valid),
		.rdata_o          (rev_word),
		.almost_empty_n_o (left_almost_empty_n_o)
	);

	// Buffers fill only on the reader's tick to keep the read side in its domain
	two_entry_buffer forward_head (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (fwd_valid & right_tick),
		.in_ready_o  (fbuf_ready),
		.in_data_i   (fwd_word),
		.out_valid_o (fbuf_valid),
		.out_ready_i (fwd_take),
		.out_data_o  (fbuf_data),
		.count_o     (fbuf_count)
	);

	two_entry_buffer reverse_head (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (rev_valid & left_tick),
		.in_ready_o  (rbuf_ready),
		.in_data_i   (rev_word),
		.out_valid_o (rbuf_valid),
		.out_ready_i (rev_take),
		.out_data_o  (rbuf_data),
		.count_o     (rbuf_count)
	);

	assign left_input_ready_o    = fwd_ir;
	assign right_input_ready_o   = rev_ir;
	assign left_output_ready_o   = rbuf_valid;
	assign right_output_ready_o  = fbuf_valid;
	assign forward_mail_flag_n_o = fwd_flag_reg;
	assign reverse_mail_flag_n_o = rev_flag_reg;
	assign left_data_bus_o       = ldata_reg;
	assign right_data_bus_o      = rdata_reg;
	assign left_data_bus_oe_o    = ~left_select_n_i & ~left_write_i;
	assign right_data_bus_oe_o   = ~right_select_n_i & ~right_write_i;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	mail_set_a: assert property (fwd_mail_wr |=> !fwd_flag_reg && forward_mailbox_reg == $past(left_data_bus_i))
		else $error("forward mail write did not lower flag or store word");
	mail_clear_a: assert property (rev_mail_rd && !rev_mail_wr |=> rev_flag_reg)
		else $error("reverse mail read did not raise flag");
	mail_hold_a: assert property (!rev_flag_reg && !rev_mail_rd |=> $stable(reverse_mailbox_reg))
		else $error("unread reverse mailbox overwritten");
	bus_drive_a: assert property (left_data_bus_oe_o |-> !left_select_n_i && !left_write_i)
		else $error("left bus driven while not a selected read");
	tick_gate_a: assert property (!left_tick |-> !left_access && !rev_take)
		else $error("left access without a left clock edge");
	prog_once_a: assert property (prog_state_reg == PROG_DONE |=> $stable(forward_full_threshold_reg))
		else $error("offset changed after programming finished");
	mail_cover_c: cover property (fwd_mail_wr ##[1:60] fwd_mail_rd);
	stream_cover_c: cover property (fwd_push && fwd_ir ##[1:60] fwd_take);
	stall_cover_c: cover property (fbuf_count == BUF_FULL ##1 fwd_take);
endmodule // bidir_mailbox_fifo
`default_nettype wire

/* File: design/mailbox_fifo_pkg.sv */
// Shared constants and pointer helpers for the bidirectional mailbox queue
package mailbox_fifo_pkg;
	localparam int              DATA_W     = 36;
	localparam int              ADDR_W     = 9;
	localparam int              PTR_W      = 10;
	localparam int              THR_W      = 9;
	localparam int              HELD_W     = 2;
	localparam logic [PTR_W-1:0] DEPTH     = 10'h200;
	localparam logic [PTR_W-1:0] PTR_ZERO  = 10'h000;
	localparam logic [PTR_W-1:0] PTR_ONE   = 10'h001;
	localparam logic [THR_W-1:0] THR_RESET = 9'h008;
	localparam logic [1:0]      INIT_RESET = 2'h0;
	localparam logic [HELD_W-1:0] BUF_EMPTY = 2'h0;
	localparam logic [HELD_W-1:0] BUF_ONE   = 2'h1;
	localparam logic [HELD_W-1:0] BUF_FULL  = 2'h2;
	localparam logic [1:0]      PROG_FWD_FULL  = 2'h0;
	localparam logic [1:0]      PROG_FWD_EMPTY = 2'h1;
	localparam logic [1:0]      PROG_REV_FULL  = 2'h2;
	localparam logic [1:0]      PROG_REV_EMPTY = 2'h3;
	localparam logic [1:0]      PROG_STEP      = 2'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO  = 36'h0_0000_0000;

	typedef enum logic [1:0] {PROG_ACTIVE, PROG_DONE} prog_state_t;

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b = g;
		for (int i = PTR_W - 2; i >= 0; i--)
		begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction
endpackage

/* File: design/queue_core.sv */
// One 512 x 36 queue with gray pointers crossed between its two port ticks
`timescale 1ns/1ps
`default_nettype none
module queue_core
	import mailbox_fifo_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              wr_tick_i,
	input  wire logic              push_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic [THR_W-1:0]  full_thr_i,
	output logic                   input_ready_o,
	output logic                   almost_full_n_o,
	input  wire logic              rd_tick_i,
	input  wire logic              pop_i,
	input  wire logic [HELD_W-1:0] held_i,
	input  wire logic [THR_W-1:0]  empty_thr_i,
	output logic                   pop_valid_o,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   almost_empty_n_o
);
	logic [DATA_W-1:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0]  wptr_reg, wptr_next, wgray_reg, wgray_next;
	logic [PTR_W-1:0]  rsync1_reg, rsync1_next, rsync2_reg, rsync2_next;
	logic [PTR_W-1:0]  rptr_reg, rptr_next, rgray_reg, rgray_next;
	logic [PTR_W-1:0]  wsync1_reg, wsync1_next, wsync2_reg, wsync2_next;
	logic [PTR_W-1:0]  used_w, used_r;
	logic [1:0]        init_reg, init_next;
	logic              ir_reg, ir_next, af_reg, af_next, ae_reg, ae_next;

	assign input_ready_o    = ir_reg;
	assign almost_full_n_o  = af_reg;
	assign almost_empty_n_o = ae_reg;
	assign pop_valid_o      = (gray2bin(wsync2_reg) != rptr_reg);
	assign rdata_o          = mem[rptr_reg[ADDR_W-1:0]];

	// Write-side state, advanced only on the writing port's tick
	always_comb
	begin
		wptr_next   = wptr_reg;
		wgray_next  = wgray_reg;
		rsync1_next = rsync1_reg;
		rsync2_next = rsync2_reg;
		init_next   = init_reg;
		ir_next     = ir_reg;
		af_next     = af_reg;
		used_w      = PTR_ZERO;
		if (wr_tick_i)
		begin
			if (push_i && ir_reg)
				wptr_next = wptr_reg + PTR_ONE;
			wgray_next  = bin2gray(wptr_next);
			rsync1_next = rgray_reg;
			rsync2_next = rsync1_reg;
			init_next   = {init_reg[0], 1'b1};
			used_w      = wptr_next - gray2bin(rsync2_reg);
			ir_next     = init_reg[0] & (used_w != DEPTH);
			af_next     = (DEPTH - used_w) > {1'b0, full_thr_i};
		end
	end

	// Read-side state; held_i counts words already moved to the buffer
	always_comb
	begin
		rptr_next   = rptr_reg;
		rgray_next  = rgray_reg;
		wsync1_next = wsync1_reg;
		wsync2_next = wsync2_reg;
		ae_next     = ae_reg;
		used_r      = PTR_ZERO;
		if (rd_tick_i)
		begin
			if (pop_i && pop_valid_o)
				rptr_next = rptr_reg + PTR_ONE;
			rgray_next  = bin2gray(rptr_next);
			wsync1_next = wgray_reg;
			wsync2_next = wsync1_reg;
			used_r      = gray2bin(wsync2_reg) - rptr_next;
			ae_next     = (used_r + {8'h00, held_i}) > {1'b0, empty_thr_i};
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (wr_tick_i && push_i && ir_reg)
			mem[wptr_reg[ADDR_W-1:0]] <= wdata_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			wptr_reg   <= PTR_ZERO;
			wgray_reg  <= PTR_ZERO;
			rsync1_reg <= PTR_ZERO;
			rsync2_reg <= PTR_ZERO;
			init_reg   <= INIT_RESET;
			ir_reg     <= 1'b0;
			af_reg     <= 1'b0;
			rptr_reg   <= PTR_ZERO;
			rgray_reg  <= PTR_ZERO;
			wsync1_reg <= PTR_ZERO;
			wsync2_reg <= PTR_ZERO;
			ae_reg     <= 1'b0;
		end
		else
		begin
			wptr_reg   <= wptr_next;
			wgray_reg  <= wgray_next;
			rsync1_reg <= rsync1_next;
			rsync2_reg <= rsync2_next;
			init_reg   <= init_next;
			ir_reg     <= ir_next;
			af_reg     <= af_next;
			rptr_reg   <= rptr_next;
			rgray_reg  <= rgray_next;
			wsync1_reg <= wsync1_next;
			wsync2_reg <= wsync2_next;
			ae_reg     <= ae_next;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	full_block_a: assert property (wr_tick_i && push_i && !ir_reg |=> $stable(wptr_reg))
		else $error("write accepted while input not ready");
	ready_init_a: assert property (!init_reg[1] |-> !ir_reg)
		else $error("input ready before two write ticks after reset");
	rd_tick_only_a: assert property (!rd_tick_i |=> $stable(rptr_reg) && $stable(wsync2_reg))
		else $error("read side moved without a read tick");
	gray_step_a: assert property (##1 $countones(wgray_reg ^ $past(wgray_reg)) <= 1)
		else $error("gray write pointer changed more than one bit");
	empty_hold_a: assert property (rd_tick_i && pop_i && !pop_valid_o |=> $stable(rptr_reg))
		else $error("pop taken from an empty queue");
	fill_cover_c: cover property (wr_tick_i && push_i && ir_reg ##[1:40] !ir_reg);
endmodule // queue_core
`default_nettype wire

/* File: design/two_entry_buffer.sv */
// Two-entry valid/ready buffer holding the head words of one queue
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
	import mailbox_fifo_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              in_valid_i,
	output logic                   in_ready_o,
	input  wire logic [DATA_W-1:0] in_data_i,
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic      [DATA_W-1:0] out_data_o,
	output logic      [HELD_W-1:0] count_o
);
	logic [DATA_W-1:0] head_reg, head_next, tail_reg, tail_next;
	logic [HELD_W-1:0] count_reg, count_next;
	logic              take, give;

	assign in_ready_o  = (count_reg != BUF_FULL);
	assign out_valid_o = (count_reg != BUF_EMPTY);
	assign out_data_o  = head_reg;
	assign count_o     = count_reg;
	assign take        = in_valid_i & in_ready_o;
	assign give        = out_valid_o & out_ready_i;

	always_comb
	begin
		head_next  = head_reg;
		tail_next  = tail_reg;
		count_next = count_reg;
		case (count_reg)
			BUF_EMPTY:
			begin
				if (take)
				begin
					head_next  = in_data_i;
					count_next = BUF_ONE;
				end
			end
			BUF_ONE:
			begin
				if (take && give)
					head_next = in_data_i;
				else if (give)
					count_next = BUF_EMPTY;
				else if (take)
				begin
					tail_next  = in_data_i;
					count_next = BUF_FULL;
				end
			end
			BUF_FULL:
			begin
				// Stall upstream rather than drop a word
				if (give)
				begin
					head_next  = tail_reg;
					count_next = BUF_ONE;
				end
			end
			default: count_next = BUF_EMPTY;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			head_reg  <= DATA_ZERO;
			tail_reg  <= DATA_ZERO;
			count_reg <= BUF_EMPTY;
		end
		else
		begin
			head_reg  <= head_next;
			tail_reg  <= tail_next;
			count_reg <= count_next;
		end
	end
endmodule // two_entry_buffer
`default_nettype wire

/* File: sim/port_clock_model.sv */
// Far-side model: the two free-running port clocks
`timescale 1ns/1ps
`default_nettype none
module port_clock_model
(
	input  wire logic clock_i,
	output logic      left_port_clock_o,
	output logic      right_port_clock_o
);
	int left_cnt  = 0;
	int right_cnt = 1;
	initial
	begin
		left_port_clock_o = 1'b0;
		right_port_clock_o = 1'b0;
	end
	// Never stopped, not even in reset: flags only move on ticks
	always @(posedge clock_i)
	begin
		left_cnt <= (left_cnt == 1) ? 0 : left_cnt + 1;
		right_cnt <= (right_cnt == 2) ? 0 : right_cnt + 1;
		if (left_cnt == 1)
			left_port_clock_o <= #1 ~left_port_clock_o;
		if (right_cnt == 2)
			right_port_clock_o <= #1 ~right_port_clock_o;
	end
endmodule // port_clock_model
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the bidirectional mailbox queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mailbox_fifo_pkg::*;
	logic                   clock_i    = 1'b0;
	logic                   rst_n_i    = 1'b0;
	logic [1:0]             sel_n      = 2'b11;
	logic [1:0]             en         = 2'b00;
	logic [1:0]             wr         = 2'b00;
	logic [1:0]             mb         = 2'b00;
	logic                   prog       = 1'b0;
	logic [1:0][DATA_W-1:0] din        = '0;
	logic [DATA_W-1:0]      q;
	wire  [1:0]             oe, in_rdy, out_rdy, af_n, ae_n, mail_n, pclk;
	wire  [DATA_W-1:0]      dout [2];
	int                     fail_count = 0;
	int                     num_checks = 0;
	localparam int          FULL_OFS   = 4;
	localparam int          EMPTY_OFS  = 2;
	// Two head-buffer words sit beyond the memory's depth
	localparam int          CAP        = int'(DEPTH) + int'(BUF_FULL);
	always #4 clock_i = ~clock_i;
	port_clock_model i_clocks (.clock_i(clock_i), .left_port_clock_o(pclk[0]),
		.right_port_clock_o(pclk[1]));
	bidir_mailbox_fifo i_dut (
		.clock_i               (clock_i),
		.rst_n_i               (rst_n_i),
		.left_port_clock_i     (pclk[0]),
		.left_select_n_i       (sel_n[0]),
		.left_port_enable_i    (en[0]),
		.left_write_i          (wr[0]),
		.left_mail_select_i    (mb[0]),
		.left_program_i        (prog),
		.left_data_bus_i       (din[0]),
		.left_data_bus_o       (dout[0]),
		.left_data_bus_oe_o    (oe[0]),
		.left_input_ready_o    (in_rdy[0]),
		.left_output_ready_o   (out_rdy[0]),
		.left_almost_full_n_o  (af_n[0]),
		.left_almost_empty_n_o (ae_n[0]),
		.right_port_clock_i    (pclk[1]),
		.right_select_n_i      (sel_n[1]),
		.right_port_enable_i   (en[1]),
		.right_write_i         (wr[1]),
		.right_mail_select_i   (mb[1]),
		.right_data_bus_i      (din[1]),
		.right_data_bus_o      (dout[1]),
		.right_data_bus_oe_o   (oe[1]),
		.right_input_ready_o   (in_rdy[1]),
		.right_output_ready_o  (out_rdy[1]),
		.right_almost_full_n_o (af_n[1]),
		.right_almost_empty_n_o(ae_n[1]),
		.forward_mail_flag_n_o (mail_n[0]),
		.reverse_mail_flag_n_o (mail_n[1])
	);
	task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task ticks(input int s, input int n);
		repeat (n) @(posedge pclk[s]);
	endtask
	// Mux select set a clock ahead, so the bus already shows the word read
	task acc(input int s, input logic w, input logic m, input logic p,
		input logic [DATA_W-1:0] d);
		int n;
		wr[s] = w;
		mb[s] = m;
		for (n = 0; n < 40 && !w && !m && out_rdy[s] !== 1'b1; n++)
			@(negedge clock_i);
		if (n == 40)
		begin
			chk(0, 1);
			tally_and_finish;
		end
		@(posedge clock_i);
		@(posedge pclk[s]);
		sel_n[s] = 1'b0;
		en[s] = 1'b1;
		prog = p;
		din[s] = d;
		@(negedge clock_i);
		q = dout[s];
		if (!w)
			chk(oe[s], 1);
		@(posedge clock_i);
		#1 sel_n[s] = 1'b1;
		en[s] = 1'b0;
		prog = 1'b0;
		din[s] = ~d;
	endtask
	initial
	begin
		repeat (6) @(posedge clock_i);
		chk({in_rdy, mail_n}, 4'b0011);
		#1 rst_n_i = 1'b1;
		ticks(0, 3);
		ticks(1, 3);
		chk({in_rdy, out_rdy, ae_n}, 6'b110000);
		// Same offsets both ways so one fill loop serves both queues
		for (int k = 0; k < 4; k++)
			acc(0, 1, 0, 1, 36'(k % 2 == 0 ? FULL_OFS : EMPTY_OFS));
		for (int s = 0; s < 2; s++)
		begin
			acc(s, 1, 1, 0, 36'h5_A5A5_A5A5);
			repeat (2) @(negedge clock_i);
			chk(mail_n[s], 0);
			acc(s, 1, 1, 0, 36'h0_0000_0001);
			acc(1 - s, 0, 1, 0, 36'h0_0000_0000);
			chk(q, 36'h5_A5A5_A5A5);
			repeat (2) @(negedge clock_i);
			chk(mail_n[s], 1);
		end
		for (int k = 0; k < 3; k++)
			acc(1, 1, 0, 0, 36'h0_0000_0100 + 36'(k));
		for (int k = 0; k < 3; k++)
		begin
			acc(0, 0, 0, 0, 36'h0_0000_0000);
			chk(q, 36'h0_0000_0100 + 36'(k));
		end
		// Far side stalls: fill past capacity, the extra write is refused
		for (int s = 0; s < 2; s++)
		begin
			for (int i = 0; i <= CAP; i++)
			begin
				if (i == CAP - FULL_OFS - 1 || i == CAP - FULL_OFS)
				begin
					ticks(s, 4);
					chk(af_n[s], i != CAP - FULL_OFS);
				end
				acc(s, 1, 0, 0, 36'(i));
			end
			ticks(1 - s, 4);
			chk({in_rdy[s], ae_n[1 - s]}, 2'b01);
			for (int i = 0; i < CAP; i++)
			begin
				if (i > CAP - EMPTY_OFS - 2)
				begin
					ticks(1 - s, 4);
					chk(ae_n[1 - s], i < CAP - EMPTY_OFS);
				end
				acc(1 - s, 0, 0, 0, 36'h0_0000_0000);
				chk(q, 36'(i));
			end
			ticks(1 - s, 4);
			chk({out_rdy[1 - s], in_rdy[s]}, 2'b01);
		end
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
